//--- verilog/clock_reset_power_supervisor.sv
// clock source selection, failure fallback, boot straps, resets and regulator modes
// assumes analog comparators deliver synchronous threshold levels
//
// Contract
// - after any reset the rc oscillator is the system clock
// - software selects rc or external 4-26 MHz clock
// - external clock failure forces rc and raises enabled interrupt
// - prescalers keep hclk <=120, fast bus <=60, slow bus <=30 MHz
// - audio pll lets audio master clock reach 8 to 192 kHz
// - boot straps at startup select flash, system memory or sram
// - above power-on threshold, option bytes load brownout setting
// - brownout threshold chosen among three levels by option bytes
// - reset held while supply below active threshold
// - enabled supply detector interrupts on fall, rise or both
// - main regulation normally, low-power regulation in stop if set
// - regulator power-down only on standby entry
// - regulator disable strap high turns the internal regulator off
// - regulator off: core domain reset pin resets core, no gpio
// - core domain reset low blocks debug at power-on reset
// - internal reset off disables por, brownout, detector, battery
// - the two straps choose regulator mode; both high is illegal
`timescale 1ns/1ps
`default_nettype none
module clock_reset_power_supervisor
   import supervisor_pkg::*;
#(
   parameter int unsigned FAIL_COUNT = FAIL_CYC
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [supervisor_pkg::ADDR_W-1:0] addr,
   input wire logic [supervisor_pkg::DATA_W-1:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [supervisor_pkg::DATA_W-1:0] rdata,
   input wire logic ext_clk_edge,
   input wire logic [1:0] boot_straps,
   input wire logic regulator_disable_strap,
   input wire logic internal_reset_disable_strap,
   input wire logic core_domain_reset_pin,
   input wire logic external_reset_pin,
   input wire logic supply_above_por,
   input wire logic [2:0] supply_above_bor,
   input wire logic supply_above_detect,
   input wire logic [1:0] option_bor_level,
   input wire logic option_valid,
   input wire logic debug_req,
   output logic system_reset,
   output logic core_reset,
   output logic sel_ext_clk,
   output logic clk_fail_irq,
   output logic supply_irq,
   output logic [1:0] boot_source,
   output logic [1:0] regu_mode,
   output logic regulator_enable,
   output logic gpio_pa_allowed,
   output logic debug_allowed,
   output logic battery_enable,
   output logic [11:0] presc_out,
   output logic audio_pll_en
);
   import supervisor_pkg::*;

   function automatic logic [3:0] clamp_div(input logic [3:0] d, input logic [3:0] lo);
      clamp_div = (d < lo) ? lo : d;
   endfunction

   sup_state_e st_reg, st_next;
   logic [DATA_W-1:0] ctrl_reg, ctrl_next, sctrl_reg, sctrl_next, rdata_next;
   logic [11:0] presc_reg, presc_next;
   logic [1:0] bor_reg, bor_next, boot_reg, boot_next, regu_reg, regu_next;
   logic fail_reg, fail_next, sel_reg, sel_next, det_reg, det_next;
   logic last_above_reg, last_above_next;
   logic [15:0] fcnt_reg, fcnt_next;
   reg_mode_e mode;
   logic irst_on, bor_ok, hold, corerst, want_ext;

   always_comb begin
      case ({internal_reset_disable_strap, regulator_disable_strap})
         2'b00: mode = REG_ON;
         2'b01: mode = REG_OFF_IRST;
         2'b10: mode = REG_OFF_NORST;
         default: mode = REG_BAD;
      endcase
      irst_on = (mode != REG_OFF_NORST);
      bor_ok = (bor_reg == BOR_OFF) || supply_above_bor[bor_reg];
      corerst = (mode != REG_ON) && !core_domain_reset_pin;
      // brownout is ignored in ST_OPTLOAD, so the option load finishes before the new level is checked
      hold = (irst_on && (!supply_above_por || (st_reg != ST_OPTLOAD && !bor_ok)))
         || !external_reset_pin || corerst || mode == REG_BAD;
   end

   always_comb begin
      st_next = st_reg;
      ctrl_next = ctrl_reg;
      sctrl_next = sctrl_reg;
      presc_next = presc_reg;
      bor_next = bor_reg;
      boot_next = boot_reg;
      regu_next = regu_reg;
      fail_next = fail_reg;
      sel_next = sel_reg;
      det_next = det_reg;
      last_above_next = supply_above_detect;
      fcnt_next = fcnt_reg;
      rdata_next = '0;
      want_ext = ctrl_reg[SEL_EXT_BIT] && !fail_reg;
      if (wr) begin
         case (addr)
            CLK_CTRL_OFS: ctrl_next = wdata;
            PRESC_OFS: presc_next = {clamp_div(wdata[11:8], 4'h4),
               clamp_div(wdata[7:4], 4'h2), clamp_div(wdata[3:0], 4'h1)};
            SUPPLY_CTRL_OFS: sctrl_next = wdata;
            default: ;
         endcase
      end
      if (rd) begin
         case (addr)
            CLK_CTRL_OFS: rdata_next = ctrl_reg;
            CLK_STAT_OFS: rdata_next = {21'h0, mode, regu_reg, boot_reg, bor_reg,
               det_reg, fail_reg, sel_reg};
            PRESC_OFS: rdata_next = {20'h0, presc_reg};
            SUPPLY_CTRL_OFS: rdata_next = sctrl_reg;
            default: rdata_next = '0;
         endcase
      end
      // external clock monitor
      if (sel_reg && !ext_clk_edge) begin
         if (fcnt_reg == 16'(FAIL_COUNT - 1)) begin
            fail_next = 1'b1;
         end else begin
            fcnt_next = fcnt_reg + 16'h1;
         end
      end else begin
         fcnt_next = '0;
      end
      if (wr && addr == CLK_CTRL_OFS && wdata[FAIL_CLR_BIT] && !fail_next) begin
         fail_next = 1'b0;
      end else if (wr && addr == CLK_CTRL_OFS && wdata[FAIL_CLR_BIT] && fcnt_reg == '0) begin
         fail_next = 1'b0;
      end
      // glitch-free switch: pass through both-off state
      case (st_reg)
         ST_HOLD: if (!hold) st_next = ST_OPTLOAD;
         ST_OPTLOAD: begin
            if (option_valid) begin
               bor_next = option_bor_level;
               boot_next = boot_straps;
               st_next = ST_RUN;
            end
         end
         ST_RUN: if (want_ext != sel_reg || fail_next) begin
            st_next = ST_SW_OFF;
            sel_next = 1'b0;
         end
         ST_SW_OFF: st_next = ST_SW_ON;
         ST_SW_ON: begin
            sel_next = want_ext && !fail_reg;
            st_next = ST_RUN;
         end
         default: st_next = ST_HOLD;
      endcase
      if (fail_next) sel_next = 1'b0;
      // supply detector edges
      if (sctrl_reg[DET_EN_BIT] && irst_on) begin
         if ((last_above_reg && !supply_above_detect && sctrl_reg[DET_FALL_BIT]) ||
            (!last_above_reg && supply_above_detect && sctrl_reg[DET_RISE_BIT])) begin
            det_next = 1'b1;
         end else if (wr && addr == SUPPLY_CTRL_OFS && wdata[DET_CLR_BIT]) begin
            det_next = 1'b0;
         end
      end else if (wr && addr == SUPPLY_CTRL_OFS && wdata[DET_CLR_BIT]) begin
         det_next = 1'b0;
      end
      // regulator mode
      if (ctrl_reg[STANDBY_REQ_BIT]) begin
         regu_next = REGU_PDOWN;
      end else if (ctrl_reg[STOP_REQ_BIT] && ctrl_reg[STOP_LP_BIT]) begin
         regu_next = REGU_LOWPWR;
      end else begin
         regu_next = REGU_MAIN;
      end
      if (regu_reg == REGU_PDOWN && !ctrl_reg[WAKE_BIT]) regu_next = REGU_PDOWN;
      if (hold) begin
         st_next = ST_HOLD;
         sel_next = 1'b0;
         ctrl_next = '0;
         fail_next = 1'b0;
         presc_next = PRESC_RST;
         regu_next = REGU_MAIN;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_reg <= ST_HOLD;
         ctrl_reg <= '0;
         sctrl_reg <= '0;
         presc_reg <= PRESC_RST;
         bor_reg <= '0;
         boot_reg <= BOOT_FLASH;
         regu_reg <= REGU_MAIN;
         fail_reg <= 1'b0;
         sel_reg <= 1'b0;
         det_reg <= 1'b0;
         last_above_reg <= 1'b0;
         fcnt_reg <= '0;
         rdata <= '0;
         system_reset <= 1'b1;
         core_reset <= 1'b1;
         sel_ext_clk <= 1'b0;
         clk_fail_irq <= 1'b0;
         supply_irq <= 1'b0;
         boot_source <= BOOT_FLASH;
         regu_mode <= REGU_MAIN;
         regulator_enable <= 1'b1;
         gpio_pa_allowed <= 1'b1;
         debug_allowed <= 1'b0;
         battery_enable <= 1'b0;
         presc_out <= PRESC_RST;
         audio_pll_en <= 1'b0;
      end else begin
         st_reg <= st_next;
         ctrl_reg <= ctrl_next;
         sctrl_reg <= sctrl_next;
         presc_reg <= presc_next;
         bor_reg <= bor_next;
         boot_reg <= boot_next;
         regu_reg <= regu_next;
         fail_reg <= fail_next;
         sel_reg <= sel_next;
         det_reg <= det_next;
         last_above_reg <= last_above_next;
         fcnt_reg <= fcnt_next;
         rdata <= rdata_next;
         system_reset <= (st_next != ST_RUN) && (st_next != ST_SW_OFF) && (st_next != ST_SW_ON);
         core_reset <= corerst;
         sel_ext_clk <= sel_next;
         clk_fail_irq <= fail_next && ctrl_next[CSS_IE_BIT];
         supply_irq <= det_next;
         boot_source <= boot_next;
         regu_mode <= regu_next;
         regulator_enable <= !regulator_disable_strap && regu_next != REGU_PDOWN;
         gpio_pa_allowed <= (mode == REG_ON);
         debug_allowed <= debug_req && !corerst;
         battery_enable <= irst_on;
         presc_out <= presc_next;
         audio_pll_en <= ctrl_next[7];
      end
   end

   chk_fail_forces_rc: assert property (@(posedge clk) disable iff (!rstn)
      fail_reg |-> ##1 !sel_ext_clk) else $error("ext clock kept after failure");
   chk_reset_rc_default: assert property (@(posedge clk) disable iff (!rstn)
      hold |=> !sel_ext_clk) else $error("rc not default in reset");
   chk_hold_resets: assert property (@(posedge clk) disable iff (!rstn)
      hold |=> system_reset) else $error("reset not held on low supply");
   chk_switch_gap: assert property (@(posedge clk) disable iff (!rstn)
      $rose(sel_ext_clk) |-> $past(!sel_ext_clk, 2)) else $error("clock switch without gap");
   chk_presc_fast: assert property (@(posedge clk) disable iff (!rstn)
      presc_out[7:4] >= 4'h2 && presc_out[11:8] >= 4'h4) else $error("bus too fast");
   chk_no_battery: assert property (@(posedge clk) disable iff (!rstn)
      mode == REG_OFF_NORST |=> !battery_enable) else $error("battery on without reset");
   chk_regulator_disable_strap_strap: assert property (@(posedge clk) disable iff (!rstn)
      regulator_disable_strap |=> !regulator_enable) else $error("regulator left on");
   chk_core_reset_pin: assert property (@(posedge clk) disable iff (!rstn)
      (mode != REG_ON && !core_domain_reset_pin) |=> core_reset && !debug_allowed)
      else $error("core reset pin ignored");
endmodule
`default_nettype wire

//--- verilog/supervisor_pkg.sv
// constants for the clock, reset and power supervisor
// assumes one 250 MHz clock and a plain register port
package supervisor_pkg;
   localparam int unsigned CLK_MHZ = 250;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 32;
   // register offsets
   localparam logic [3:0] CLK_CTRL_OFS = 4'h0;
   localparam logic [3:0] CLK_STAT_OFS = 4'h4;
   localparam logic [3:0] PRESC_OFS = 4'h8;
   localparam logic [3:0] SUPPLY_CTRL_OFS = 4'hC;
   // clock control fields
   localparam int unsigned SEL_EXT_BIT = 0;
   localparam int unsigned CSS_IE_BIT = 1;
   localparam int unsigned FAIL_CLR_BIT = 2;
   localparam int unsigned STOP_LP_BIT = 3;
   localparam int unsigned STOP_REQ_BIT = 4;
   localparam int unsigned STANDBY_REQ_BIT = 5;
   localparam int unsigned WAKE_BIT = 6;
   // supply control fields
   localparam int unsigned DET_EN_BIT = 0;
   localparam int unsigned DET_FALL_BIT = 1;
   localparam int unsigned DET_RISE_BIT = 2;
   localparam int unsigned DET_CLR_BIT = 3;
   // prescaler fields: hclk div [3:0], fast div [7:4], slow div [11:8]
   localparam int unsigned RC_FREQ_MHZ = 16;
   localparam int unsigned EXT_MIN_MHZ = 4;
   localparam int unsigned EXT_MAX_MHZ = 26;
   localparam int unsigned HCLK_MAX_MHZ = 120;
   localparam int unsigned FAST_MAX_MHZ = 60;
   localparam int unsigned SLOW_MAX_MHZ = 30;
   localparam int unsigned AUDIO_MIN_KHZ = 8;
   localparam int unsigned AUDIO_MAX_KHZ = 192;
   // ext clock considered lost after this many ns without an edge
   localparam int unsigned FAIL_NS = 1000;
   localparam int unsigned FAIL_CYC = FAIL_NS * CLK_MHZ / 1000;
   // reset dividers already meet the bus limits: slow 4, fast 2, hclk 1
   localparam logic [11:0] PRESC_RST = 12'h421;
   // boot straps
   localparam logic [1:0] BOOT_FLASH = 2'h0;
   localparam logic [1:0] BOOT_SYSMEM = 2'h1;
   localparam logic [1:0] BOOT_SRAM = 2'h3;
   // brownout level codes held in option bytes
   localparam logic [1:0] BOR_OFF = 2'h3;
   typedef enum logic [1:0] {REG_ON, REG_OFF_IRST, REG_OFF_NORST, REG_BAD} reg_mode_e;
   typedef enum logic [1:0] {REGU_MAIN, REGU_LOWPWR, REGU_PDOWN} regu_e;
   typedef enum logic [2:0] {ST_HOLD, ST_OPTLOAD, ST_RUN, ST_SW_OFF, ST_SW_ON} sup_state_e;
endpackage

//--- testbench/ext_supervisor_model.sv
// external supply supervisor driving both reset pins of the block
// assumes supply good levels come from the bench as clean levels
`timescale 1ns/1ps
`default_nettype none
module ext_supervisor_model #(
   parameter int DLY = 3
) (
   input wire logic clk,
   input wire logic core_ok,
   input wire logic main_hi,
   input wire logic main_lo,
   input wire logic irst_off,
   output logic core_domain_reset_pin,
   output logic external_reset_pin
);
   logic [7:0] cnt = 8'h00;
   wire logic good = core_ok && (irst_off ? main_lo : main_hi);
   // release is delayed, assertion is immediate
   always_ff @(posedge clk) begin
      if (!good) cnt <= 8'h00;
      else if (cnt != 8'(DLY)) cnt <= cnt + 8'h01;
   end
   assign core_domain_reset_pin = good && (cnt == 8'(DLY));
   assign external_reset_pin = !irst_off || main_lo;
endmodule
`default_nettype wire

//--- testbench/clock_reset_power_supervisor_tb_top.sv
// self-checking bench for the clock, reset and power supervisor
// assumes the package and the supervisor model are compiled first
`timescale 1ns/1ps
`default_nettype none
module clock_reset_power_supervisor_tb_top;
   import supervisor_pkg::*;
   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, ext_clk_edge = 1'b0, ext_run = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic [1:0] boot_straps = 2'h1, option_bor_level = 2'h0, boot_source, regu_mode;
   logic regulator_disable_strap = 1'b0, internal_reset_disable_strap = 1'b0;
   logic core_domain_reset_pin, external_reset_pin, core_ok = 1'b1;
   logic supply_above_por = 1'b1, supply_above_detect = 1'b1, option_valid = 1'b1;
   logic debug_req = 1'b0;
   logic [2:0] supply_above_bor = 3'h7;
   logic system_reset, core_reset, sel_ext_clk, clk_fail_irq, supply_irq, regulator_enable;
   logic gpio_pa_allowed, debug_allowed, battery_enable, audio_pll_en;
   logic [11:0] presc_out;
   int failures = 0, checked = 0, i;
   clock_reset_power_supervisor #(.FAIL_COUNT(8)) u_clock_reset_power_supervisor (
      .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .ext_clk_edge(ext_clk_edge), .boot_straps(boot_straps),
      .regulator_disable_strap(regulator_disable_strap),
      .internal_reset_disable_strap(internal_reset_disable_strap),
      .core_domain_reset_pin(core_domain_reset_pin), .external_reset_pin(external_reset_pin),
      .supply_above_por(supply_above_por), .supply_above_bor(supply_above_bor),
      .supply_above_detect(supply_above_detect), .option_bor_level(option_bor_level),
      .option_valid(option_valid), .debug_req(debug_req), .system_reset(system_reset),
      .core_reset(core_reset), .sel_ext_clk(sel_ext_clk), .clk_fail_irq(clk_fail_irq),
      .supply_irq(supply_irq), .boot_source(boot_source), .regu_mode(regu_mode),
      .regulator_enable(regulator_enable), .gpio_pa_allowed(gpio_pa_allowed),
      .debug_allowed(debug_allowed), .battery_enable(battery_enable),
      .presc_out(presc_out), .audio_pll_en(audio_pll_en));
   ext_supervisor_model u_ext_supervisor_model (.clk(clk), .core_ok(core_ok), .main_hi(1'b1),
      .main_lo(1'b1), .irst_off(internal_reset_disable_strap),
      .core_domain_reset_pin(core_domain_reset_pin), .external_reset_pin(external_reset_pin));
   always #2 clk = ~clk;
   always @(posedge clk) ext_clk_edge <= ext_run & ~ext_clk_edge;
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk) begin addr <= a; wdata <= d; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
      tk(3);
   endtask
   task automatic rd_reg(input logic [3:0] a);
      @(posedge clk) begin addr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      #1 v = rdata;
   endtask
   task automatic do_reset;
      @(posedge clk) rstn <= 1'b0;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      for (i = 0; i < 40 && system_reset !== 1'b0; i++) tk(1);
   endtask
   task automatic t_boot;
      logic [1:0] codes[3];
      codes = '{BOOT_FLASH, BOOT_SYSMEM, BOOT_SRAM};
      foreach (codes[k]) begin
         boot_straps <= codes[k];
         do_reset();
         check("boot_source", boot_source, codes[k]);
         check("sel_ext_clk", sel_ext_clk, 0);
         check("regu_mode", regu_mode, 0);
         check("regulator_enable", regulator_enable, 1);
         check("battery_enable", battery_enable, 1);
      end
      option_valid <= 1'b0;
      do_reset();
      check("system_reset", system_reset, 1);
      option_valid <= 1'b1;
      for (i = 0; i < 40 && system_reset !== 1'b0; i++) tk(1);
      check("system_reset", system_reset, 0);
      rd_reg(4'h2);
      check("unmapped", v, 0);
      $display("test boot done");
   endtask
   task automatic t_clk;
      ext_run <= 1'b1;
      wr_reg(CLK_CTRL_OFS, 32'h83);
      rd_reg(CLK_CTRL_OFS);
      check("clk ctrl readback", v, 32'h83);
      for (i = 0; i < 40 && sel_ext_clk !== 1'b1; i++) tk(1);
      check("sel_ext_clk", sel_ext_clk, 1);
      check("audio_pll_en", audio_pll_en, 1);
      check("clk_fail_irq", clk_fail_irq, 0);
      ext_run <= 1'b0;
      for (i = 0; i < 60 && clk_fail_irq !== 1'b1; i++) tk(1);
      check("clk_fail_irq", clk_fail_irq, 1);
      check("sel_ext_clk", sel_ext_clk, 0);
      wr_reg(CLK_CTRL_OFS, 32'h06);
      check("clk_fail_irq", clk_fail_irq, 0);
      wr_reg(PRESC_OFS, 32'h0);
      check("presc", {presc_out[3:0] >= 4'h1, presc_out[7:4] >= 4'h2, presc_out[11:8] >= 4'h4},
         3'h7);
      $display("test clock done");
   endtask
   task automatic t_det;
      wr_reg(SUPPLY_CTRL_OFS, 32'h3);
      supply_above_detect <= 1'b0;
      for (i = 0; i < 40 && supply_irq !== 1'b1; i++) tk(1);
      check("supply_irq fall", supply_irq, 1);
      wr_reg(SUPPLY_CTRL_OFS, 32'hD);
      wr_reg(SUPPLY_CTRL_OFS, 32'h5);
      check("supply_irq clear", supply_irq, 0);
      supply_above_detect <= 1'b1;
      for (i = 0; i < 40 && supply_irq !== 1'b1; i++) tk(1);
      check("supply_irq rise", supply_irq, 1);
      $display("test detector done");
   endtask
   task automatic t_power;
      wr_reg(CLK_CTRL_OFS, 32'h18);
      check("regu_mode stop", regu_mode, 1);
      wr_reg(CLK_CTRL_OFS, 32'h40);
      check("regu_mode wake", regu_mode, 0);
      wr_reg(CLK_CTRL_OFS, 32'h20);
      check("regu_mode standby", regu_mode, 2);
      for (int l = 0; l < 3; l++) begin
         option_bor_level <= 2'(l);
         do_reset();
         supply_above_bor[l] <= 1'b0;
         tk(4);
         check("bor reset", system_reset, 1);
         supply_above_bor <= 3'h7;
         for (i = 0; i < 40 && system_reset !== 1'b0; i++) tk(1);
      end
      supply_above_por <= 1'b0;
      tk(4);
      check("por reset", system_reset, 1);
      supply_above_por <= 1'b1;
      $display("test power done");
   endtask
   task automatic t_regulator_disable_strap;
      regulator_disable_strap <= 1'b1;
      core_ok <= 1'b0;
      debug_req <= 1'b1;
      do_reset();
      check("regulator_enable", regulator_enable, 0);
      check("gpio_pa_allowed", gpio_pa_allowed, 0);
      check("debug_allowed", debug_allowed, 0);
      check("core_reset", core_reset, 1);
      core_ok <= 1'b1;
      for (i = 0; i < 40 && core_reset !== 1'b0; i++) tk(1);
      check("core_reset", core_reset, 0);
      tk(2);
      check("debug_allowed", debug_allowed, 1);
      regulator_disable_strap <= 1'b0;
      internal_reset_disable_strap <= 1'b1;
      do_reset();
      check("battery_enable", battery_enable, 0);
      supply_above_por <= 1'b0;
      tk(4);
      check("por ignored", system_reset, 0);
      supply_above_por <= 1'b1;
      regulator_disable_strap <= 1'b1;
      do_reset();
      check("illegal straps", system_reset, 1);
      regulator_disable_strap <= 1'b0;
      internal_reset_disable_strap <= 1'b0;
      do_reset();
      $display("test regulator off done");
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      t_boot();
      t_clk();
      t_det();
      t_power();
      t_regulator_disable_strap();
      summarize();
   end
   initial begin
      #40000;
      failures++;
      summarize();
   end
endmodule
`default_nettype wire
